/* File: common/atxfi_cfg.svh */
// Constants for the auxiliary transmit frame-insertion block.
// Assumes one core clock; all counts are in core clock cycles.
// Overview of operation
// - 64-bit word index wraps at 31, 39, 47 or 95 for 8/10/12/24G rates.
// - 12.16512 and 24.33024 Gbps always use the 64-bit word interface.
// - 8.11008/10.1376 Gbps use 64-bit words only after negotiation down.
// - Each data word targets the position shown one plus latency cycles earlier.
// - The override mask is aligned with its data word, same latency offset.
// - A set mask bit puts the user data bit into the frame, except bits 63:32 in 32-bit mode.
// - Mask over a comma or start/end slot raises the error next cycle.
// - One control-slot flag per byte lane for the current word index.
// - In master mode a resync pulse clears frame indices, restarts timing.
// - Resync is synchronous to the core clock; its rising edge acts.
// - The 12-bit frame number loads the resync value after the edge.
// - One error bit per lane: masked data overwrote a control word.
// - Basic-frame index counts 0 to 255, zero one clock after resync.
`ifndef ATXFI_CFG_SVH
`define ATXFI_CFG_SVH
`define ATXFI_LANES 8
`define ATXFI_X_LAST 8'h00FF
`define ATXFI_Z_LAST 8'h0095
`define ATXFI_BFN_W 12
`define ATXFI_WR_LAT 0
`define ATXFI_CW_PER_BF 16
`define ATXFI_SEQ_N_0G6 7'h03
`define ATXFI_SEQ_N_1G2 7'h07
`define ATXFI_SEQ_N_2G4 7'h0F
`define ATXFI_SEQ_N_3G0 7'h13
`define ATXFI_SEQ_N_4G9 7'h1F
`define ATXFI_SEQ_N_6G1 7'h27
`define ATXFI_SEQ_N_8G1 7'h3F
`define ATXFI_SEQ_N_9G8 7'h3F
`define ATXFI_SEQ_N_10G 7'h4F
`define ATXFI_SEQ_W_8G1 7'h1F
`define ATXFI_SEQ_W_10G 7'h27
`define ATXFI_SEQ_W_12G 7'h2F
`define ATXFI_SEQ_W_24G 7'h5F
`endif

/* File: common/atxfi_pkg.sv */
// Types shared by the auxiliary transmit frame-insertion block.
// Assumes nothing beyond the constants header.
package atxfi_pkg;
    // Line rate; Gray order along the negotiation ladder
    typedef enum logic [3:0] {
        ATXFI_R0G6 = 4'h0,
        ATXFI_R1G2 = 4'h1,
        ATXFI_R2G4 = 4'h3,
        ATXFI_R3G0 = 4'h2,
        ATXFI_R4G9 = 4'h6,
        ATXFI_R6G1 = 4'h7,
        ATXFI_R8G1 = 4'h5,
        ATXFI_R9G8 = 4'h4,
        ATXFI_R10G = 4'hC,
        ATXFI_R12G = 4'hD,
        ATXFI_R24G = 4'hF
    } atxfi_rate_t;

    typedef struct packed {
        logic [11:0] radio_frame_number;
        logic [7:0] hyperframe_index;
        logic [7:0] basic_frame_index;
        logic [6:0] word_index;
    } atxfi_pos_t;
endpackage

/* File: hw/atxfi_delay_line.sv */
// Fixed-depth shift register carrying position flags forward in time.
// Assumes DEPTH is at least one.
`timescale 1ns/1ns
`default_nettype none
module atxfi_delay_line #(
    parameter int W = 8,
    parameter int DEPTH = 1
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] stage [DEPTH];

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            stage[0] <= '0;
        end else begin
            stage[0] <= d_i;
        end
    end

    for (genvar i = 1; i < DEPTH; i++) begin : g_stage
        always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
                stage[i] <= '0;
            end else begin
                stage[i] <= stage[i-1];
            end
        end
    end

    assign q_o = stage[DEPTH-1];
endmodule
`default_nettype wire

/* File: hw/atxfi_tx_insert.sv */
// Transmit-side auxiliary insertion: frame position counters, control
// slot flags, masked data insertion and overwrite error reporting.
// Assumes all inputs are synchronous to ref_clk_i.
`timescale 1ns/1ns
`default_nettype none
`include "atxfi_cfg.svh"
module atxfi_tx_insert import atxfi_pkg::*; #(
    parameter int WR_LAT = `ATXFI_WR_LAT
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire atxfi_rate_t rate_i,
    input wire logic autoneg_from_high_i,
    input wire logic radio_controller_master_i,
    input wire logic sync_rfp_i,
    input wire logic [11:0] bfn_resync_value_i,
    input wire logic [63:0] side_tx_word_in_i,
    input wire logic [63:0] side_tx_bit_override_i,
    input wire logic [63:0] frame_src_i,
    output logic [63:0] frame_word_o,
    output logic wide_mode_o,
    output atxfi_pos_t pos_o,
    output logic rfp_o,
    output logic hfp_o,
    output logic [7:0] side_tx_control_slot_flags_o,
    output logic [7:0] tx_err_o
);
    localparam int LANES = `ATXFI_LANES;
    localparam int DEPTH = WR_LAT + 1;

    // ------------------------------------------------------------
    // Word width and index range
    // ------------------------------------------------------------
    logic wide;
    logic [6:0] seq_max;

    always_comb begin
        unique case (rate_i)
            ATXFI_R12G, ATXFI_R24G: wide = 1'b1;
            ATXFI_R8G1, ATXFI_R10G: wide = autoneg_from_high_i;
            default: wide = 1'b0;
        endcase
    end

    always_comb begin
        unique case (rate_i)
            ATXFI_R0G6: seq_max = `ATXFI_SEQ_N_0G6;
            ATXFI_R1G2: seq_max = `ATXFI_SEQ_N_1G2;
            ATXFI_R2G4: seq_max = `ATXFI_SEQ_N_2G4;
            ATXFI_R3G0: seq_max = `ATXFI_SEQ_N_3G0;
            ATXFI_R4G9: seq_max = `ATXFI_SEQ_N_4G9;
            ATXFI_R6G1: seq_max = `ATXFI_SEQ_N_6G1;
            ATXFI_R8G1: seq_max = wide ? `ATXFI_SEQ_W_8G1 : `ATXFI_SEQ_N_8G1;
            ATXFI_R9G8: seq_max = `ATXFI_SEQ_N_9G8;
            ATXFI_R10G: seq_max = wide ? `ATXFI_SEQ_W_10G : `ATXFI_SEQ_N_10G;
            ATXFI_R12G: seq_max = `ATXFI_SEQ_W_12G;
            ATXFI_R24G: seq_max = `ATXFI_SEQ_W_24G;
            default: seq_max = `ATXFI_SEQ_N_0G6;
        endcase
    end

    assign wide_mode_o = wide;

    // ------------------------------------------------------------
    // Resync edge and frame position counters
    // ------------------------------------------------------------
    logic sync_q;
    logic resync;
    logic seq_end;
    logic x_end;
    logic z_end;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sync_q <= 1'b0;
        end else begin
            sync_q <= sync_rfp_i;
        end
    end

    // Only the rising edge counts, so a held level restarts timing once
    assign resync = radio_controller_master_i & sync_rfp_i & ~sync_q;
    assign seq_end = pos_o.word_index >= seq_max;
    assign x_end = pos_o.basic_frame_index == `ATXFI_X_LAST;
    assign z_end = pos_o.hyperframe_index >= `ATXFI_Z_LAST;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pos_o <= '0;
        end else if (resync) begin
            pos_o.word_index <= 7'h00;
            pos_o.basic_frame_index <= 8'h00;
            pos_o.hyperframe_index <= 8'h00;
            pos_o.radio_frame_number <= bfn_resync_value_i;
        end else begin
            // A rate drop below the current index wraps at once
            pos_o.word_index <= seq_end ? 7'h00 : pos_o.word_index + 7'h01;
            if (seq_end) begin
                pos_o.basic_frame_index <= pos_o.basic_frame_index + 8'h01;
                if (x_end) begin
                    pos_o.hyperframe_index <= z_end ? 8'h00
                        : pos_o.hyperframe_index + 8'h01;
                    if (z_end) begin
                        pos_o.radio_frame_number <=
                            pos_o.radio_frame_number + 12'h001;
                    end
                end
            end
        end
    end

    assign hfp_o = (pos_o.word_index == 7'h00)
        && (pos_o.basic_frame_index == 8'h00);
    assign rfp_o = hfp_o && (pos_o.hyperframe_index == 8'h00);

    // ------------------------------------------------------------
    // Control-slot flags per byte lane
    // ------------------------------------------------------------
    // Lane p holds bits [63-8p -: 8]; a 32-bit word sits in lanes 4..7,
    // so its first byte is bits 31:24 as user logic packs it.
    logic [10:0] bf_bytes;
    logic [10:0] cw_bytes;
    logic [10:0] word_base;
    logic [7:0] ctrl_now;
    logic [7:0] ctrl_d;
    logic [63:0] eff_mask;

    assign bf_bytes = ({4'h0, seq_max} + 11'h001) << (wide ? 3 : 2);
    assign cw_bytes = bf_bytes / 11'(`ATXFI_CW_PER_BF);
    assign word_base = {4'h0, pos_o.word_index} << (wide ? 3 : 2);

    for (genvar p = 0; p < LANES; p++) begin : g_lane
        localparam logic [10:0] WIDE_IDX = 11'(p);
        localparam logic [10:0] NARROW_IDX = 11'(p % 4);
        logic valid;
        assign valid = wide || (p >= 4);
        assign ctrl_now[p] = valid
            && (word_base + (wide ? WIDE_IDX : NARROW_IDX)) < cw_bytes;
        assign eff_mask[63-8*p -: 8] = valid
            ? side_tx_bit_override_i[63-8*p -: 8] : 8'h00;
    end

    assign side_tx_control_slot_flags_o = ctrl_now;

    // Flags travel forward so that they meet the late data word
    atxfi_delay_line #(
        .W(LANES),
        .DEPTH(DEPTH)
    ) u_ctrl_delay (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .d_i(ctrl_now),
        .q_o(ctrl_d)
    );

    // ------------------------------------------------------------
    // Insertion and overwrite error
    // ------------------------------------------------------------
    logic [7:0] lane_hit;

    for (genvar p = 0; p < LANES; p++) begin : g_err
        // The comma and start/end bytes lie inside the control word
        assign lane_hit[p] = ctrl_d[p] & (|eff_mask[63-8*p -: 8]);
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            frame_word_o <= 64'h0000_0000_0000_0000;
        end else begin
            frame_word_o <= (eff_mask & side_tx_word_in_i)
                | (~eff_mask & frame_src_i);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            tx_err_o <= 8'h00;
        end else begin
            tx_err_o <= lane_hit;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    logic [7:0] warm;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            warm <= 8'h00;
        end else if (warm != 8'hFF) begin
            warm <= warm + 8'h01;
        end
    end

    sequence s_seq_wrap;
        seq_end && !resync;
    endsequence
    sequence s_bf_last;
        s_seq_wrap ##0 x_end;
    endsequence

    // A rate drop may leave the index above the new range for one cycle
    property p_seq_range;
        $stable(seq_max) |-> pos_o.word_index <= seq_max;
    endproperty
    a_seq_range: assert property (p_seq_range)
        else $error("word index beyond range");

    property p_wide_high;
        (rate_i == ATXFI_R12G || rate_i == ATXFI_R24G) |-> wide_mode_o;
    endproperty
    a_wide_high: assert property (p_wide_high)
        else $error("high rate not in wide mode");

    property p_narrow_keep;
        (rate_i == ATXFI_R8G1 || rate_i == ATXFI_R10G)
            |-> wide_mode_o == autoneg_from_high_i;
    endproperty
    a_narrow_keep: assert property (p_narrow_keep)
        else $error("wide mode wrong at mid rate");

    property p_ctrl_delay;
        (warm > 8'(DEPTH)) |-> ctrl_d == $past(ctrl_now, DEPTH);
    endproperty
    a_ctrl_delay: assert property (p_ctrl_delay)
        else $error("control flags not aligned to latency");

    property p_override;
        1'b1 |=> (frame_word_o & $past(eff_mask))
            == ($past(side_tx_word_in_i) & $past(eff_mask));
    endproperty
    a_override: assert property (p_override)
        else $error("masked bit not inserted");

    property p_src;
        1'b1 |=> (frame_word_o & ~$past(eff_mask))
            == ($past(frame_src_i) & ~$past(eff_mask));
    endproperty
    a_src: assert property (p_src)
        else $error("unmasked bit not from source");

    property p_err;
        (|lane_hit) |=> (tx_err_o != 8'h00) ##1 1'b1;
    endproperty
    a_err: assert property (p_err)
        else $error("overwrite error missing");

    property p_ctrl_first;
        (pos_o.word_index == 7'h00)
            |-> ctrl_now[wide_mode_o ? 0 : 4];
    endproperty
    a_ctrl_first: assert property (p_ctrl_first)
        else $error("first lane not flagged as control");

    property p_resync;
        resync |=> pos_o.word_index == 7'h00
            && pos_o.basic_frame_index == 8'h00
            && pos_o.hyperframe_index == 8'h00
            && pos_o.radio_frame_number == $past(bfn_resync_value_i);
    endproperty
    a_resync: assert property (p_resync)
        else $error("resync did not restart frame");

    property p_x_wrap;
        s_bf_last |=> pos_o.basic_frame_index == 8'h00 ##1
            pos_o.word_index == 7'h01 || $past(resync);
    endproperty
    a_x_wrap: assert property (p_x_wrap)
        else $error("basic frame index did not wrap");
endmodule
`default_nettype wire

/* File: verif/atxfi_user_model.sv */
// User-side model that fills auxiliary words for the insertion block.
// Assumes zero extra write latency and the block's own clock.
`timescale 1ns/1ns
`default_nettype none
module atxfi_user_model import atxfi_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic bad_i,
    input wire atxfi_pos_t pos_i,
    input wire logic [7:0] flags_i,
    output logic [63:0] word_o,
    output logic [63:0] mask_o
);
    // ----------------------------------------
    // Word and mask, one cycle after position
    // ----------------------------------------
    logic [63:0] ctrl_bits;
    always_comb begin
        for (int p = 0; p < 8; p++) begin
            ctrl_bits[63-8*p -: 8] = {8{flags_i[p]}};
        end
    end
    // First byte sent sits in the top bits of each half
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            word_o <= 64'h0;
        end else begin
            word_o <= {2{pos_i.hyperframe_index, pos_i.basic_frame_index,
                         1'b0, pos_i.word_index, 8'h3C}};
        end
    end
    // Control bytes are spared unless told to trespass on purpose
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mask_o <= 64'h0;
        end else if (bad_i) begin
            mask_o <= '1;
        end else begin
            mask_o <= ~ctrl_bits & 64'hF0F0_FF00_0FF0_FFFF;
        end
    end
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the auxiliary transmit insertion block.
// Assumes zero extra write latency; the user model feeds the data side.
`timescale 1ns/1ns
`default_nettype none
module tb import atxfi_pkg::*;;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    atxfi_rate_t rate_i = ATXFI_R0G6;
    logic autoneg = 1'b0;
    logic master = 1'b0;
    logic sync = 1'b0;
    logic bad = 1'b0;
    logic [11:0] bfn_val = 12'h000;
    logic [63:0] src = 64'h0;
    logic [63:0] word, mask, fword;
    logic wide, rfp, hfp;
    atxfi_pos_t pos;
    logic [7:0] flags, err;
    int err_total = 0;
    int compares = 0;

    always #4 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) src <= src + 64'h0123_4567_89AB_CDEF;

    atxfi_tx_insert #(.WR_LAT(0)) u_atxfi_tx_insert (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .rate_i(rate_i),
        .autoneg_from_high_i(autoneg), .radio_controller_master_i(master),
        .sync_rfp_i(sync), .bfn_resync_value_i(bfn_val),
        .side_tx_word_in_i(word), .side_tx_bit_override_i(mask),
        .frame_src_i(src), .frame_word_o(fword), .wide_mode_o(wide),
        .pos_o(pos), .rfp_o(rfp), .hfp_o(hfp),
        .side_tx_control_slot_flags_o(flags), .tx_err_o(err));
    atxfi_user_model u_atxfi_user_model (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .bad_i(bad), .pos_i(pos),
        .flags_i(flags), .word_o(word), .mask_o(mask));

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic chk(input string nm, input logic [63:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Merge and error expectations come from inputs seen one and two
    // cycles back, so any slip in the alignment shows at once
    task automatic t_insert(input int n);
        logic [63:0] mp, wp, sp, mg;
        logic [7:0] f1, f2, e;
        for (int i = 0; i < n; i++) begin
            @(negedge ref_clk_i);
            if (i >= 2) begin
                e = 8'h00;
                for (int p = 0; p < 8; p++) begin
                    e[p] = f2[p] & |mp[63-8*p -: 8];
                end
                mg = (mp & wp) | (~mp & sp);
                chk("tx_err", 64'(err), 64'(e));
                if (!wide) mg[63:32] = sp[63:32];
                chk("frame word", fword, mg);
            end
            if (rate_i == ATXFI_R0G6) begin
                e = (pos.word_index == 7'h00) ? 8'h10 : 8'h00;
                chk("ctrl flags", 64'(flags), 64'(e));
            end
            // At the top rate the first six wide words are control bytes
            if (rate_i == ATXFI_R24G) begin
                e = (pos.word_index < 7'h06) ? 8'hFF : 8'h00;
                chk("wide ctrl flags", 64'(flags), 64'(e));
            end
            f2 = f1;
            f1 = flags;
            mp = mask;
            wp = word;
            sp = src;
        end
        $display("insert test done");
    endtask

    task automatic t_rates();
        atxfi_rate_t rt[6] = '{ATXFI_R8G1, ATXFI_R10G, ATXFI_R12G,
                               ATXFI_R24G, ATXFI_R8G1, ATXFI_R10G};
        logic [6:0] mx[6] = '{7'h1F, 7'h27, 7'h2F, 7'h5F, 7'h3F, 7'h4F};
        logic [6:0] top;
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk_i);
            rate_i <= rt[i];
            autoneg <= (i < 2);
            repeat (3) @(negedge ref_clk_i);
            top = 7'h00;
            repeat (200) begin
                @(negedge ref_clk_i);
                if (pos.word_index > top) top = pos.word_index;
            end
            chk("wide mode", 64'(wide), 64'(i < 4));
            chk("index max", 64'(top), 64'(mx[i]));
        end
        $display("rate test done");
    endtask

    task automatic t_resync();
        @(posedge ref_clk_i);
        rate_i <= ATXFI_R0G6;
        bfn_val <= 12'h3FF;
        sync <= 1'b1;
        @(posedge ref_clk_i);
        sync <= 1'b0;
        @(negedge ref_clk_i);
        chk("slave frame no", 64'(pos.radio_frame_number), 64'(0));
        @(posedge ref_clk_i);
        master <= 1'b1;
        bad <= 1'b1;
        bfn_val <= 12'hA5C;
        sync <= 1'b1;
        repeat (2) @(negedge ref_clk_i);
        chk("resync pos", 64'(pos), {29'h0, 12'hA5C, 23'h0});
        chk("resync rfp", 64'(rfp & hfp), 64'(1));
        repeat (2) @(negedge ref_clk_i);
        chk("comma err", 64'(err), 64'(8'h10));
        @(negedge ref_clk_i);
        chk("held level", 64'(pos.word_index), 64'(3));
        @(posedge ref_clk_i);
        sync <= 1'b0;
        $display("resync test done");
    endtask

    // Basic-frame wrap at the narrowest rate; the hyperframe step and
    // the pulse pair both hang on the one wrap edge
    task automatic t_bf_wrap();
        logic [7:0] z0;
        int n;
        n = 0;
        @(negedge ref_clk_i);
        while (n < 1100 && !(pos.basic_frame_index == 8'hFF
                && pos.word_index == 7'h03)) begin
            @(negedge ref_clk_i);
            n++;
        end
        chk("bf wrap in time", 64'(n < 1100), 64'(1));
        z0 = pos.hyperframe_index + 8'h01;
        @(negedge ref_clk_i);
        chk("bf wrap z", 64'(pos.hyperframe_index), 64'(z0));
        chk("bf wrap x", 64'(pos.basic_frame_index), 64'(0));
        chk("bf wrap pulses", 64'({rfp, hfp}), 64'(2'h1));
        $display("bf wrap test done");
    endtask

    initial begin
        repeat (4) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk("reset pos", 64'(pos), 64'(0));
        chk("reset out", 64'({rfp, hfp, err}), 64'(10'h300));
        @(posedge ref_clk_i);
        rst_i <= 1'b0;
        $display("reset test done");
        t_insert(40);
        t_rates();
        t_resync();
        t_bf_wrap();
        t_insert(24);
        @(posedge ref_clk_i);
        bad <= 1'b0;
        rate_i <= ATXFI_R24G;
        t_insert(300);
        wrap_up();
    end
endmodule
`default_nettype wire
